// ==== psram_pkg.sv ====
package psram_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int PSRAM_ADDR_W = 17;
  localparam int PSRAM_LANES  = 4;
  localparam int PSRAM_LANE_W = 8;
  localparam int PSRAM_SEED_W = 2;

  // ****************************************************************
  // Burst order strap encodings and reset values
  // ****************************************************************
  localparam logic       PSRAM_ORDER_LINEAR      = 1'h0;
  localparam logic       PSRAM_ORDER_INTERLEAVED = 1'h1;
  localparam logic       PSRAM_ORDER_RST         = PSRAM_ORDER_INTERLEAVED;
  localparam logic [2:0] PSRAM_STRAP_SYNC_RST    = 3'h7;

  // ****************************************************************
  // Burst counter steps
  // ****************************************************************
  localparam logic [1:0] PSRAM_STEP_RST = 2'h0;
  localparam logic [1:0] PSRAM_STEP_ONE = 2'h1;

  // ****************************************************************
  // Access kinds carried through the pipeline
  // ****************************************************************
  typedef enum logic [1:0] {
    PSRAM_OP_IDLE  = 2'b00,
    PSRAM_OP_READ  = 2'b01,
    PSRAM_OP_WRITE = 2'b10
  } psram_op_type;

endpackage

// ==== psram_port.sv ====
`timescale 1ns/100ps

// What this block does
// - Registered address selects one word of 128K.
// - Low two address bits seed burst counter.
// - Byte strobes write lanes only with write.
// - Write request sampled only on qualified edges.
// - Advance input steps burst counter when qualified and an access is in flight.
// - Load input low takes a fresh address when selected.
// - Unqualified clock edges are ignored except by the strap filter.
// - Selected only with first/third low, second high.
// - Output enable gates data drivers asynchronously.
// - Drivers off during every write data cycle.
// - Drivers off while deselected and one clock after.
// - Clock qualifier high freezes, never deselects.
// - Input data captured in data register.
// - Strap picks linear or interleaved burst order.
module psram_port
  import psram_pkg::*;
#(
  parameter int ADDR_W = PSRAM_ADDR_W,
  parameter int LANES  = PSRAM_LANES,
  parameter int LANE_W = PSRAM_LANE_W
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  // Address and burst control
  input  wire logic [ADDR_W-1:PSRAM_SEED_W] i_address_upper,
  input  wire logic [PSRAM_SEED_W-1:0]    i_burst_seed_bits,
  input  wire logic                       i_advance_or_load,
  input  wire logic                       i_burst_order_strap,
  // Access control
  input  wire logic                       i_clock_qualify_n,
  input  wire logic                       i_write_request_n,
  input  wire logic [LANES-1:0]           i_byte_lane_write_n,
  input  wire logic                       i_select_low_first,
  input  wire logic                       i_select_high,
  input  wire logic                       i_select_low_third,
  input  wire logic                       i_output_enable_n,
  // Data pins
  input  wire logic [LANES*LANE_W-1:0]    i_data_io,
  output logic      [LANES*LANE_W-1:0]    o_data_io,
  output logic      [LANES*LANE_W-1:0]    o_data_io_oe,
  // Parity pins
  input  wire logic [LANES-1:0]           i_lane_parity_io,
  output logic      [LANES-1:0]           o_lane_parity_io,
  output logic      [LANES-1:0]           o_lane_parity_io_oe
);

  localparam int WORD_W = LANES * (LANE_W + 1);
  localparam int DEPTH  = 2 ** ADDR_W;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]        strap_sync;
    logic              order;
    psram_op_type      op1;
    psram_op_type      op2;
    psram_op_type      op3;
    logic [ADDR_W-1:0] base;
    logic [1:0]        step;
    logic [ADDR_W-1:0] addr1;
    logic [ADDR_W-1:0] addr2;
    logic [ADDR_W-1:0] addr3;
    logic [LANES-1:0]  bw1;
    logic [LANES-1:0]  bw2;
    logic [LANES-1:0]  bw3;
    logic [WORD_W-1:0] wr_data;
    logic [WORD_W-1:0] rd_data;
    logic              drive;
  } psram_state_type;

  localparam psram_state_type STATE_RST = '{
    strap_sync: PSRAM_STRAP_SYNC_RST,
    order:      PSRAM_ORDER_RST,
    op1:        PSRAM_OP_IDLE,
    op2:        PSRAM_OP_IDLE,
    op3:        PSRAM_OP_IDLE,
    base:       '0,
    step:       PSRAM_STEP_RST,
    addr1:      '0,
    addr2:      '0,
    addr3:      '0,
    bw1:        '0,
    bw2:        '0,
    bw3:        '0,
    wr_data:    '0,
    rd_data:    '0,
    drive:      1'h0
  };

  psram_state_type   state_q;
  psram_state_type   state_d;
  logic              qual;
  logic              selected;
  logic              drive_pins;
  logic [WORD_W-1:0] pin_word;
  logic [WORD_W-1:0] fwd_word;
  logic [1:0]        low_bits;

  assign qual     = ~i_clock_qualify_n;
  assign selected = ~i_select_low_first & i_select_high & ~i_select_low_third;

  // The enable is deliberately not synchronised: it must act without a clock edge.
  assign drive_pins = state_q.drive & ~i_output_enable_n;

  // ****************************************************************
  // Per-lane storage, forwarding and pin mapping
  // ****************************************************************
  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      logic [LANE_W:0] mem_q [0:DEPTH-1];
      logic [LANE_W:0] pin_lane;
      logic [LANE_W:0] wr_lane;
      logic [LANE_W:0] rd_lane;

      assign pin_lane = {i_lane_parity_io[l], i_data_io[l*LANE_W +: LANE_W]};
      assign wr_lane  = state_q.wr_data[l*(LANE_W+1) +: LANE_W+1];
      assign pin_word[l*(LANE_W+1) +: LANE_W+1] = pin_lane;

      // Writes retire one qualified edge after their data is captured, so a read
      // issued right behind a write must see both pending words merged in.
      always_comb begin
        rd_lane = mem_q[state_q.addr1];
        if (state_q.op3 == PSRAM_OP_WRITE && state_q.addr3 == state_q.addr1
            && state_q.bw3[l]) begin
          rd_lane = wr_lane;
        end
        if (state_q.op2 == PSRAM_OP_WRITE && state_q.addr2 == state_q.addr1
            && state_q.bw2[l]) begin
          rd_lane = pin_lane;
        end
      end
      assign fwd_word[l*(LANE_W+1) +: LANE_W+1] = rd_lane;

      always_ff @(posedge i_clk) begin
        if (qual && state_q.op3 == PSRAM_OP_WRITE && state_q.bw3[l]) begin
          mem_q[state_q.addr3] <= wr_lane;
        end
      end

      assign o_data_io[l*LANE_W +: LANE_W] = state_q.rd_data[l*(LANE_W+1) +: LANE_W];
      assign o_lane_parity_io[l]            = state_q.rd_data[l*(LANE_W+1) + LANE_W];
      assign o_data_io_oe[l*LANE_W +: LANE_W] = {LANE_W{drive_pins}};
      assign o_lane_parity_io_oe[l]         = drive_pins;
    end
  endgenerate

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d  = state_q;
    low_bits = 2'h0;
    // The strap is a pin, so it is filtered before it may change the order.
    state_d.strap_sync = {state_q.strap_sync[1:0], i_burst_order_strap};
    if (state_q.strap_sync[1] == state_q.strap_sync[2]) begin
      state_d.order = state_q.strap_sync[2];
    end
    // Without a qualified edge every pipeline stage simply holds.
    if (qual) begin
      state_d.op3     = state_q.op2;
      state_d.addr3   = state_q.addr2;
      state_d.bw3     = state_q.bw2;
      state_d.wr_data = pin_word;
      state_d.op2     = state_q.op1;
      state_d.addr2   = state_q.addr1;
      state_d.bw2     = state_q.bw1;
      // Drivers come on only for a read data cycle, so writes, deselects and
      // the clock right after a deselect all leave them off.
      state_d.drive = (state_q.op1 == PSRAM_OP_READ);
      if (state_q.op1 == PSRAM_OP_READ) begin
        state_d.rd_data = fwd_word;
      end
      if (!i_advance_or_load) begin
        if (selected) begin
          state_d.op1  = i_write_request_n ? PSRAM_OP_READ : PSRAM_OP_WRITE;
          state_d.base = {i_address_upper, i_burst_seed_bits};
          state_d.step = PSRAM_STEP_RST;
        end else begin
          state_d.op1 = PSRAM_OP_IDLE;
        end
      end else begin
        // A burst continues the access in flight; after a deselect nothing runs
        // until the controller loads a fresh address.
        unique case (state_q.op1)
          PSRAM_OP_IDLE:  state_d.op1 = PSRAM_OP_IDLE;
          PSRAM_OP_READ,
          PSRAM_OP_WRITE: state_d.step = state_q.step + PSRAM_STEP_ONE;
          default:        state_d.op1 = PSRAM_OP_IDLE;
        endcase
      end
      if (state_q.order == PSRAM_ORDER_LINEAR) begin
        low_bits = state_d.base[1:0] + state_d.step;
      end else begin
        low_bits = state_d.base[1:0] ^ state_d.step;
      end
      state_d.addr1 = {state_d.base[ADDR_W-1:PSRAM_SEED_W], low_bits};
      state_d.bw1   = (state_d.op1 == PSRAM_OP_WRITE) ? ~i_byte_lane_write_n : '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_load_address;
    @(posedge i_clk) disable iff (!i_rst_n)
    (qual && !i_advance_or_load && selected)
      |=> (state_q.base == $past({i_address_upper, i_burst_seed_bits}))
          && (state_q.step == PSRAM_STEP_RST);
  endproperty
  a_load_address: assert property (p_load_address)
    else $error("Loaded address not taken from the pins.");

  property p_advance;
    @(posedge i_clk) disable iff (!i_rst_n)
    (qual && i_advance_or_load && state_q.op1 != PSRAM_OP_IDLE)
      |=> (state_q.step == $past(state_q.step) + PSRAM_STEP_ONE)
          && $stable(state_q.base) && $stable(state_q.op1);
  endproperty
  a_advance: assert property (p_advance)
    else $error("Burst counter did not advance.");

  property p_burst_low_bits;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q.op1 != PSRAM_OP_IDLE) |->
      (state_q.addr1[1:0] == ($past(state_q.order) == PSRAM_ORDER_LINEAR
        ? state_q.base[1:0] + state_q.step : state_q.base[1:0] ^ state_q.step));
  endproperty
  a_burst_low_bits: assert property (p_burst_low_bits)
    else $error("Burst low address bits wrong for the burst order.");

  property p_write_lanes;
    @(posedge i_clk) disable iff (!i_rst_n)
    (qual && !i_advance_or_load && selected && !i_write_request_n)
      |=> state_q.op1 == PSRAM_OP_WRITE && state_q.bw1 == ~$past(i_byte_lane_write_n);
  endproperty
  a_write_lanes: assert property (p_write_lanes)
    else $error("Write lanes do not follow the byte strobes.");

  property p_read_no_lanes;
    @(posedge i_clk) disable iff (!i_rst_n)
    (qual && !i_advance_or_load && selected && i_write_request_n)
      |=> state_q.op1 == PSRAM_OP_READ && state_q.bw1 == '0;
  endproperty
  a_read_no_lanes: assert property (p_read_no_lanes)
    else $error("Read started with write lanes set.");

  property p_deselect;
    @(posedge i_clk) disable iff (!i_rst_n)
    (qual && !i_advance_or_load && !selected) ##1 qual |=> !state_q.drive;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("Drivers on after a deselect.");

  property p_write_no_drive;
    @(posedge i_clk) disable iff (!i_rst_n)
    (qual && state_q.op1 == PSRAM_OP_WRITE) |=> !state_q.drive [*1] ##0 o_data_io_oe == '0;
  endproperty
  a_write_no_drive: assert property (p_write_no_drive)
    else $error("Drivers on in a write data cycle.");

  property p_read_drive;
    @(posedge i_clk) disable iff (!i_rst_n)
    (qual && !i_advance_or_load && selected && i_write_request_n) ##1 qual
      |=> state_q.drive;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("Read data not presented two qualified edges after the address.");

  property p_oe_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_lane_parity_io_oe != '0) |-> !i_output_enable_n && state_q.drive
      && (o_data_io_oe == '1);
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("Drivers on without output enable.");

  property p_freeze;
    @(posedge i_clk) disable iff (!i_rst_n)
    !qual |=> $stable(state_q.op1) && $stable(state_q.addr1) && $stable(state_q.drive)
      && $stable(state_q.rd_data) && $stable(state_q.op3);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State changed on an unqualified edge.");

  property p_stretch;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q.drive && !qual) ##1 !qual |=> state_q.drive;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("Holding the qualifier dropped the read cycle.");

  property p_capture;
    @(posedge i_clk) disable iff (!i_rst_n)
    (qual && state_q.op2 == PSRAM_OP_WRITE) |=> state_q.wr_data == $past(pin_word);
  endproperty
  a_capture: assert property (p_capture)
    else $error("Write data not captured from the pins.");

  c_burst_read: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q.op1 == PSRAM_OP_READ && state_q.step == 2'h3);
  c_write: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    qual && state_q.op3 == PSRAM_OP_WRITE && state_q.bw3 != '0);
  c_freeze: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q.drive && !qual ##1 !qual);
  c_forward: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    qual && state_q.op1 == PSRAM_OP_READ && state_q.op2 == PSRAM_OP_WRITE
      && state_q.addr2 == state_q.addr1);

endmodule

// ==== psram_ctrl_model.sv ====
`timescale 1ns/100ps

// ****************************************************************
// Memory controller model
// ****************************************************************
module psram_ctrl_model
  import psram_pkg::*;
(
  // Clock
  input  wire logic i_clk
);
  logic [16:0] addr;
  logic [16:0] base;
  logic [35:0] dq_d;
  logic [36:0] notes[$];
  logic [36:0] pipe[2];
  logic [35:0] ref_mem[int];
  logic [3:0]  be_n;
  logic [2:0]  cs_pins;
  logic [1:0]  step;
  logic        advance;
  logic        wn;
  logic        qn;
  logic        oen;
  logic        strap;
  logic        order;
  logic        act;
  logic        opw;
  int          seed_v = 37364;

  initial begin
    {addr, base, dq_d, be_n, cs_pins, step, advance, wn, oen, strap, order, act, opw} = '0;
    qn = 1'b1;
    pipe = '{default: '0};
  end

  function automatic logic [31:0] rnd();
    return $random(seed_v);
  endfunction

  // One qualified cycle; the released data bus shows a fresh pattern.
  task automatic issue(input logic load, input logic [2:0] cs, input logic wr,
                       input logic [3:0] ben, input logic [16:0] a);
    logic [35:0] wd;
    logic [35:0] tmp;
    logic [16:0] ea;
    wd = 36'({rnd(), rnd()});
    @(negedge i_clk);
    qn = 1'b0;
    advance = ~load;
    cs_pins = cs;
    wn = ~wr;
    be_n = ben;
    addr = load ? a : 17'(rnd());
    if (load) begin
      act = (cs == 3'b010);
      opw = wr;
      base = a;
      step = '0;
    end else begin
      step = step + PSRAM_STEP_ONE;
    end
    ea = {base[16:2], (order == PSRAM_ORDER_INTERLEAVED) ? base[1:0] ^ step : base[1:0] + step};
    tmp = ref_mem.exists(ea) ? ref_mem[ea] : 'x;
    if (act && opw) begin
      for (int l = 0; l < PSRAM_LANES; l++) begin
        if (!ben[l]) begin
          tmp[8*l +: 8] = wd[8*l +: 8];
          tmp[32+l] = wd[32+l];
        end
      end
      ref_mem[ea] = tmp;
    end
    notes.push_back((act && !opw) ? {1'b1, tmp} : 37'h0);
    dq_d = pipe[1][36] ? pipe[1][35:0] : 36'({rnd(), rnd()});
    pipe[1] = pipe[0];
    pipe[0] = {act && opw, wd};
  endtask

  task automatic stall(input int n);
    repeat (n) begin
      @(negedge i_clk);
      qn = 1'b1;
      {addr, advance, wn, be_n, cs_pins} = 26'(rnd());
    end
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps

// ****************************************************************
// Bench top
// ****************************************************************
module tb_top;
  logic        i_clk;
  logic        i_rst_n;
  logic [31:0] dev_dq;
  logic [31:0] dev_oe;
  logic [3:0]  dev_par;
  logic [3:0]  dev_par_oe;
  logic [35:0] pins;
  logic [36:0] exp_now;
  logic [36:0] exp_next;
  logic [16:0] a;
  int          n_mismatch = 0;
  int          tests_run = 0;

  psram_ctrl_model ctrl_i (
    .i_clk (i_clk)
  );

  // Pin level: the device wins only on bits that it drives.
  assign pins = ({dev_par_oe, dev_oe} & {dev_par, dev_dq})
              | (~{dev_par_oe, dev_oe} & ctrl_i.dq_d);

  psram_port psram_port_i (
    .i_clk               (i_clk),
    .i_rst_n             (i_rst_n),
    .i_address_upper     (ctrl_i.addr[16:2]),
    .i_burst_seed_bits   (ctrl_i.addr[1:0]),
    .i_advance_or_load   (ctrl_i.advance),
    .i_burst_order_strap (ctrl_i.strap),
    .i_clock_qualify_n   (ctrl_i.qn),
    .i_write_request_n   (ctrl_i.wn),
    .i_byte_lane_write_n (ctrl_i.be_n),
    .i_select_low_first  (ctrl_i.cs_pins[2]),
    .i_select_high       (ctrl_i.cs_pins[1]),
    .i_select_low_third  (ctrl_i.cs_pins[0]),
    .i_output_enable_n   (ctrl_i.oen),
    .i_data_io           (pins[31:0]),
    .o_data_io           (dev_dq),
    .o_data_io_oe        (dev_oe),
    .i_lane_parity_io    (pins[35:32]),
    .o_lane_parity_io    (dev_par),
    .o_lane_parity_io_oe (dev_par_oe)
  );

  task automatic check_drive(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t drive got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_data(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t data got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic burst(input logic wr, input logic [3:0] ben, input logic [16:0] b);
    ctrl_i.issue(1'b1, 3'b010, wr, ben, b);
    repeat (3) ctrl_i.issue(1'b0, 3'b010, wr, ben, b);
    for (int i = 0; i < 4; i++) begin
      ctrl_i.issue(1'b1, 3'b010, 1'b0, 4'hF, {b[16:2], 2'(i)});
    end
  endtask

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    give_verdict();
  end

  // Outputs after a qualified edge answer the op taken one qualified edge earlier.
  initial begin
    exp_now = '0;
    exp_next = '0;
    @(posedge i_rst_n);
    forever begin
      @(posedge i_clk);
      if (ctrl_i.qn === 1'b0) begin
        exp_now = exp_next;
        exp_next = (ctrl_i.notes.size() > 0) ? ctrl_i.notes.pop_front() : 37'h0;
      end
      #20;
      check_drive({dev_par_oe, dev_oe}, {36{exp_now[36] & ~ctrl_i.oen}});
      if (exp_now[36]) check_data({dev_par, dev_dq}, exp_now[35:0]);
    end
  end

  initial begin
    i_rst_n = 1'b0;
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    check_drive({dev_par_oe, dev_oe}, 36'h0);
    $display("test reset done");
    i_rst_n = 1'b1;
    repeat (4) ctrl_i.issue(1'b1, 3'b110, 1'b0, 4'hF, '0);
    a = 17'(ctrl_i.rnd());
    a[1:0] = 2'h1;
    burst(1'b1, 4'h0, a);
    burst(1'b0, 4'hF, a);
    $display("test linear bursts done");
    for (int i = 0; i < 8; i++) begin
      ctrl_i.issue(1'b1, 3'b010, 1'b1, 4'(ctrl_i.rnd()), a);
      ctrl_i.issue(1'b1, 3'b010, 1'b0, 4'(ctrl_i.rnd()), a);
    end
    $display("test lane strobes done");
    for (int c = 0; c < 8; c++) begin
      ctrl_i.issue(1'b1, 3'(c), 1'(c), 4'h0, a);
      ctrl_i.issue(1'b0, 3'(c), 1'b0, 4'h0, a);
    end
    $display("test select decode done");
    for (int i = 0; i < 6; i++) begin
      ctrl_i.issue(1'(i != 1), 3'b010, 1'(i == 2), 4'(ctrl_i.rnd()), a);
      ctrl_i.stall(i % 3);
    end
    $display("test clock qualifier done");
    ctrl_i.oen = 1'b1;
    burst(1'b0, 4'hF, a);
    ctrl_i.oen = 1'b0;
    $display("test output enable done");
    ctrl_i.strap = 1'b1;
    repeat (4) ctrl_i.issue(1'b1, 3'b000, 1'b0, 4'hF, a);
    ctrl_i.order = 1'b1;
    a = 17'(ctrl_i.rnd());
    a[1:0] = 2'h1;
    burst(1'b1, 4'h0, a);
    burst(1'b0, 4'hF, a);
    repeat (3) ctrl_i.issue(1'b1, 3'b110, 1'b0, 4'hF, a);
    $display("test interleaved bursts done");
    repeat (2) @(posedge i_clk);
    #30;
    give_verdict();
  end
endmodule
